// ---- fsc_cpu_model.sv ----
// Core side: issues FP operations and transfer-register loads.
// Assumes the block samples these pulses on the rising edge of clk.
`timescale 1ns/1ps
module fsc_cpu_model (
    input wire logic clk, // Core clock
    output logic opValid, // Op executes
    output fsc_pkg::fsc_cause_t opExcept, // Exceptions raised
    output logic xferWrite, // Load transfer reg
    output fsc_pkg::fsc_word_t xferIn // Value to load
);
    import fsc_pkg::*;
    initial begin
        opValid = 1'b0;
        opExcept = 6'h00;
        xferWrite = 1'b0;
        xferIn = 32'h0;
    end
    // Ops back to back after an optional stall; bit 5 error, 1 and 0 underflow/inexact
    task automatic run(input int q[$], input int gap);
        repeat (gap) @(posedge clk);
        foreach (q[i]) begin
            @(posedge clk);
            opValid <= 1'b1;
            opExcept <= 6'(q[i]);
        end
        @(posedge clk);
        opValid <= 1'b0;
        opExcept <= ~opExcept; // Released lines show no stale value
    endtask
    task automatic load(input fsc_word_t v);
        @(posedge clk);
        xferWrite <= 1'b1;
        xferIn <= v;
        @(posedge clk);
        xferWrite <= 1'b0;
        xferIn <= ~v;
    endtask
endmodule

// ---- fsc_defs.svh ----
// Constants of the FP status/control block: offsets, fields, resets.
// Assumes a single 125 MHz core clock and byte-addressed word registers.

`ifndef FSC_DEFS_SVH
`define FSC_DEFS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define FSC_OFF_CTRL 4'h0
`define FSC_OFF_XFER 4'h4
`define FSC_OFF_IST 4'h8
`define FSC_OFF_IMSK 4'hC

// ---------------------------------------------------------------
// Status/control fields
// ---------------------------------------------------------------
`define FSC_RSV_HI 31
`define FSC_RSV_LO 22
`define FSC_FR_BIT 21
`define FSC_SZ_BIT 20
`define FSC_PR_BIT 19
`define FSC_DN_BIT 18
`define FSC_CAUSE_HI 17
`define FSC_CAUSE_LO 12
`define FSC_EN_HI 11
`define FSC_EN_LO 7
`define FSC_FLAG_HI 6
`define FSC_FLAG_LO 2
`define FSC_RND_HI 1
`define FSC_RND_LO 0

// Exception index inside the 6-bit cause vector
`define FSC_EXC_ERR 5
`define FSC_EXC_INV 4
`define FSC_EXC_DIVZ 3
`define FSC_EXC_OVF 2
`define FSC_EXC_UNF 1
`define FSC_EXC_INEX 0

// ---------------------------------------------------------------
// Reset values and codes
// ---------------------------------------------------------------
`define FSC_RND_NEAREST 2'h0
`define FSC_RND_ZERO 2'h1
`define FSC_RST_RND 2'h1
`define FSC_RST_DN 1'h1
`define FSC_RST_CAUSE 6'h00
`define FSC_RST_EN 5'h00
`define FSC_RST_FLAG 5'h00

// Interrupt status bits
`define FSC_IRQ_W 3
`define FSC_IRQ_EXC 0
`define FSC_IRQ_TRAP 1
`define FSC_IRQ_XFER 2

`endif

// ---- fsc_exc_merge.sv ----
// Next-value logic for the cause and flag fields.
// Assumes one-cycle operation strobes on the core clock.
`timescale 1ns/1ps
`include "fsc_defs.svh"
module fsc_exc_merge (
    input wire fsc_pkg::fsc_cause_t curCause, // Stored cause
    input wire fsc_pkg::fsc_five_t curFlag, // Stored flags
    input wire fsc_pkg::fsc_five_t enable, // Stored enables
    input wire logic opValid, // FP operation executes
    input wire fsc_pkg::fsc_cause_t opExcept, // Its exceptions
    input wire logic swWrite, // Software writes the register
    input wire fsc_pkg::fsc_cause_t swCause, // Written cause
    input wire fsc_pkg::fsc_five_t swFlag, // Written flags
    output logic [5:0] next_cause, // Cause after this cycle
    output logic [4:0] next_flag, // Flags after this cycle
    output logic trapHit // Exception leads to a trap
);
    import fsc_pkg::*;

    fsc_cause_t hit;
    fsc_cause_t baseCause;
    fsc_five_t baseFlag;

    assign hit = opValid ? opExcept : 6'h00;
    // Operation clears the cause, then its own bits land
    assign baseCause = opValid ? 6'h00 : (swWrite ? swCause : curCause);
    assign next_cause = baseCause | hit;
    // Error has no flag slot, only bits 4..0 accumulate
    assign baseFlag = swWrite ? swFlag : curFlag;
    assign next_flag = baseFlag | hit[4:0];
    // Error always traps; the rest only when enabled
    assign trapHit = hit[`FSC_EXC_ERR] | (|(hit[4:0] & enable));
endmodule

// ---- fsc_pkg.sv ----
// Types shared by the FP status/control block.
// Assumes fsc_defs.svh is available on the include path.
package fsc_pkg;
    typedef logic [5:0] fsc_cause_t;
    typedef logic [4:0] fsc_five_t;
    typedef logic [31:0] fsc_word_t;
    typedef enum {SEL_NONE, SEL_CTRL, SEL_XFER, SEL_IST, SEL_IMSK} fsc_sel_t;
endpackage

// ---- fsc_status_control.sv ----
// FP status/control register, transfer register and exception logic.
// Assumes the core drives all strobes on clk; strobes may share a cycle.
`timescale 1ns/1ps
`include "fsc_defs.svh"
module fsc_status_control #(
    parameter int ADDR_W = 4
) (
    input wire logic clk, // Core clock
    input wire logic rst, // Synchronous reset, high
    input wire logic [ADDR_W-1:0] addr, // Register byte address
    input wire fsc_pkg::fsc_word_t wrData, // Write data
    input wire logic wrStrobe, // Write strobe
    input wire logic rdStrobe, // Read strobe
    output fsc_pkg::fsc_word_t rdData, // Read data, next cycle
    input wire logic opValid, // FP operation executes
    input wire fsc_pkg::fsc_cause_t opExcept, // Exceptions it raised
    input wire logic xferWrite, // FPU loads transfer reg
    input wire fsc_pkg::fsc_word_t xferIn, // FPU value to load
    output fsc_pkg::fsc_word_t xferOut, // Transfer reg contents
    output logic [1:0] roundingSelect, // Rounding mode
    output logic roundNearest, // Mode 00 decoded
    output logic roundReserved, // Reserved mode written
    output fsc_pkg::fsc_five_t exceptEnable, // Exception enables
    output fsc_pkg::fsc_cause_t causeOut, // Cause field
    output fsc_pkg::fsc_five_t flagOut, // Sticky flags
    output logic bankSwap, // Register bank swap
    output logic pairMove, // 64-bit move size
    output logic doublePrec, // Double precision
    output logic denormZero, // Denormals as zero
    output logic excTrap, // Trap request pulse
    output logic irq // Interrupt level
);
    import fsc_pkg::*;

    // ---------------------------------------------------------------
    // Parameter check
    // ---------------------------------------------------------------
    generate
        if (ADDR_W < 4) begin : gAddrCheck
            $error("fsc_status_control: ADDR_W must be at least 4");
        end
    endgenerate

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    // Full-width compare, so aliases above bit 3 stay unmapped
    function automatic logic isAt(input logic [ADDR_W-1:0] a,
                                  input logic [3:0] off);
        isAt = (a == ADDR_W'(off));
    endfunction

    function automatic fsc_sel_t decode(input logic [ADDR_W-1:0] a);
        if (isAt(a, `FSC_OFF_CTRL)) begin
            decode = SEL_CTRL;
        end else if (isAt(a, `FSC_OFF_XFER)) begin
            decode = SEL_XFER;
        end else if (isAt(a, `FSC_OFF_IST)) begin
            decode = SEL_IST;
        end else if (isAt(a, `FSC_OFF_IMSK)) begin
            decode = SEL_IMSK;
        end else begin
            decode = SEL_NONE;
        end
    endfunction

    // Pack irq-width bits into the low end of a word
    function automatic fsc_word_t padIrq(input logic [`FSC_IRQ_W-1:0] v);
        padIrq = {{(32-`FSC_IRQ_W){1'b0}}, v};
    endfunction

    // ---------------------------------------------------------------
    // Storage
    // ---------------------------------------------------------------
    fsc_cause_t cause;
    fsc_five_t flag;
    fsc_five_t enable;
    logic [1:0] rmode;
    logic frBit;
    logic szBit;
    logic prBit;
    logic dnBit;
    fsc_word_t xfer;
    logic [`FSC_IRQ_W-1:0] irqStatus;
    logic [`FSC_IRQ_W-1:0] irqMask;

    // ---------------------------------------------------------------
    // Address decode
    // ---------------------------------------------------------------
    fsc_sel_t sel;
    wire wrCtrl;
    wire wrXfer;
    wire wrMask;
    wire rdIst;

    assign sel = decode(addr);
    assign wrCtrl = wrStrobe && (sel == SEL_CTRL);
    assign wrXfer = wrStrobe && (sel == SEL_XFER);
    assign wrMask = wrStrobe && (sel == SEL_IMSK);
    assign rdIst = rdStrobe && (sel == SEL_IST);

    // ---------------------------------------------------------------
    // Written fields
    // ---------------------------------------------------------------
    wire fsc_cause_t wCause;
    wire fsc_five_t wEnable;
    wire fsc_five_t wFlag;
    wire [1:0] wRmode;

    assign wCause = wrData[`FSC_CAUSE_HI:`FSC_CAUSE_LO];
    assign wEnable = wrData[`FSC_EN_HI:`FSC_EN_LO];
    assign wFlag = wrData[`FSC_FLAG_HI:`FSC_FLAG_LO];
    assign wRmode = wrData[`FSC_RND_HI:`FSC_RND_LO];

    // ---------------------------------------------------------------
    // Cause and flag merge
    // ---------------------------------------------------------------
    logic [5:0] next_cause;
    logic [4:0] next_flag;
    logic trapHit;

    fsc_exc_merge uMerge (
        .curCause(cause),
        .curFlag(flag),
        .enable(enable),
        .opValid(opValid),
        .opExcept(opExcept),
        .swWrite(wrCtrl),
        .swCause(wCause),
        .swFlag(wFlag),
        .next_cause(next_cause),
        .next_flag(next_flag),
        .trapHit(trapHit)
    );

    // ---------------------------------------------------------------
    // Control register image
    // ---------------------------------------------------------------
    fsc_word_t ctrlWord;

    // Upper ten bits are hard zero and ignore writes
    assign ctrlWord = {
        {(`FSC_RSV_HI-`FSC_RSV_LO+1){1'b0}},
        frBit, szBit, prBit, dnBit,
        cause, enable, flag, rmode
    };

    // ---------------------------------------------------------------
    // Interrupt events
    // ---------------------------------------------------------------
    wire anyExc;
    logic [`FSC_IRQ_W-1:0] irqEvent;
    logic [`FSC_IRQ_W-1:0] next_irqStatus;

    assign anyExc = opValid && (|opExcept);

    always_comb begin
        irqEvent = '0;
        irqEvent[`FSC_IRQ_EXC] = anyExc;
        irqEvent[`FSC_IRQ_TRAP] = trapHit;
        irqEvent[`FSC_IRQ_XFER] = xferWrite;
    end

    // A read clears, but an event in that cycle is kept
    assign next_irqStatus = (rdIst ? '0 : irqStatus) | irqEvent;

    // ---------------------------------------------------------------
    // Read data
    // ---------------------------------------------------------------
    fsc_word_t readMux;

    always_comb begin
        case (sel)
            SEL_CTRL: readMux = ctrlWord;
            SEL_XFER: readMux = xfer;
            SEL_IST: readMux = padIrq(irqStatus);
            SEL_IMSK: readMux = padIrq(irqMask);
            default: readMux = 32'h00000000;
        endcase
    end

    // ---------------------------------------------------------------
    // Exception fields
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            cause <= `FSC_RST_CAUSE;
            flag <= `FSC_RST_FLAG;
        end else begin
            cause <= next_cause;
            flag <= next_flag;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            enable <= `FSC_RST_EN;
        end else if (wrCtrl) begin
            enable <= wEnable;
        end
    end

    // ---------------------------------------------------------------
    // Mode bits
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            rmode <= `FSC_RST_RND;
            frBit <= 1'b0;
            szBit <= 1'b0;
            prBit <= 1'b0;
            dnBit <= `FSC_RST_DN;
        end else if (wrCtrl) begin
            rmode <= wRmode;
            frBit <= wrData[`FSC_FR_BIT];
            szBit <= wrData[`FSC_SZ_BIT];
            prBit <= wrData[`FSC_PR_BIT];
            dnBit <= wrData[`FSC_DN_BIT];
        end
    end

    // ---------------------------------------------------------------
    // Transfer register
    // ---------------------------------------------------------------
    // Contents carry no meaning after reset; cleared only so
    // simulation never shows an unknown word on xferOut.
    // FPU load wins over a software write in the same cycle.
    always_ff @(posedge clk) begin
        if (rst) begin
            xfer <= 32'h00000000;
        end else if (xferWrite) begin
            xfer <= xferIn;
        end else if (wrXfer) begin
            xfer <= wrData;
        end
    end

    // ---------------------------------------------------------------
    // Interrupt status and mask
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            irqStatus <= '0;
            irqMask <= '0;
        end else begin
            irqStatus <= next_irqStatus;
            if (wrMask) begin
                irqMask <= wrData[`FSC_IRQ_W-1:0];
            end
        end
    end

    // Level output looks at the updated status, so it drops
    // in the same cycle as the clearing read answers.
    always_ff @(posedge clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_irqStatus & (wrMask ?
                   wrData[`FSC_IRQ_W-1:0] : irqMask));
        end
    end

    // ---------------------------------------------------------------
    // Trap pulse and read answer
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            excTrap <= 1'b0;
        end else begin
            excTrap <= trapHit;
        end
    end

    // Data valid only in the cycle after the strobe, zero elsewhere
    always_ff @(posedge clk) begin
        if (rst) begin
            rdData <= 32'h00000000;
        end else if (rdStrobe) begin
            rdData <= readMux;
        end else begin
            rdData <= 32'h00000000;
        end
    end

    // ---------------------------------------------------------------
    // Registered mode outputs
    // ---------------------------------------------------------------
    // Mirrored copies track the next state, so they equal the
    // stored fields in every cycle while staying pure flops.
    logic [1:0] next_rmode;

    assign next_rmode = wrCtrl ? wRmode : rmode;

    always_ff @(posedge clk) begin
        if (rst) begin
            roundingSelect <= `FSC_RST_RND;
            roundNearest <= 1'b0;
            roundReserved <= 1'b0;
        end else begin
            roundingSelect <= next_rmode;
            roundNearest <= (next_rmode == `FSC_RND_NEAREST);
            // Reserved codes are stored; the datapath must not use them
            roundReserved <= next_rmode[1];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            exceptEnable <= `FSC_RST_EN;
            causeOut <= `FSC_RST_CAUSE;
            flagOut <= `FSC_RST_FLAG;
        end else begin
            exceptEnable <= wrCtrl ? wEnable : enable;
            causeOut <= next_cause;
            flagOut <= next_flag;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bankSwap <= 1'b0;
            pairMove <= 1'b0;
            doublePrec <= 1'b0;
            denormZero <= `FSC_RST_DN;
        end else if (wrCtrl) begin
            bankSwap <= wrData[`FSC_FR_BIT];
            pairMove <= wrData[`FSC_SZ_BIT];
            doublePrec <= wrData[`FSC_PR_BIT];
            denormZero <= wrData[`FSC_DN_BIT];
        end
    end

    // ---------------------------------------------------------------
    // Transfer output
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            xferOut <= 32'h00000000;
        end else if (xferWrite) begin
            xferOut <= xferIn;
        end else if (wrXfer) begin
            xferOut <= wrData;
        end
    end
endmodule

// ---- fsc_status_control_properties.sv ----
// Port-level checks for the FP status/control block.
// Assumes every request is driven on the rising edge of clk.
`timescale 1ns/1ps
module fsc_status_control_chk #(
    parameter int ADDR_W = 4
) (
    input wire logic clk, // Core clock
    input wire logic rst, // Sync reset
    input wire logic [ADDR_W-1:0] addr, // Byte address
    input wire fsc_pkg::fsc_word_t wrData, // Write data
    input wire logic wrStrobe, // Write
    input wire logic rdStrobe, // Read
    input wire fsc_pkg::fsc_word_t rdData, // Read answer
    input wire logic opValid, // Op executes
    input wire fsc_pkg::fsc_cause_t opExcept, // Op exceptions
    input wire logic xferWrite, // Transfer load
    input wire fsc_pkg::fsc_word_t xferIn, // Load value
    input wire fsc_pkg::fsc_word_t xferOut, // Transfer reg
    input wire logic [1:0] roundingSelect, // Rounding mode
    input wire logic roundNearest, // Mode 00
    input wire logic roundReserved, // Mode 1x
    input wire fsc_pkg::fsc_five_t exceptEnable, // Enables
    input wire fsc_pkg::fsc_cause_t causeOut, // Cause
    input wire fsc_pkg::fsc_five_t flagOut, // Flags
    input wire logic excTrap // Trap pulse
);
    import fsc_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    wire ctrlWr = wrStrobe && (addr == '0);
    wire ctrlRd = rdStrobe && (addr == '0);

    property p_ctrlRead;
        ctrlRd |=> rdData[31:22] == '0 && rdData[17:0] == {$past(causeOut),
            $past(exceptEnable), $past(flagOut), $past(roundingSelect)};
    endproperty
    a_ctrlRead: assert property (p_ctrlRead) else $error("control read image wrong");
    property p_causeOp;
        opValid |=> causeOut == $past(opExcept);
    endproperty
    a_causeOp: assert property (p_causeOp) else $error("cause not op result");
    property p_causeHold;
        !opValid && !ctrlWr |=> $stable(causeOut);
    endproperty
    a_causeHold: assert property (p_causeHold) else $error("cause moved idle");
    property p_flagOp;
        opValid && !ctrlWr |=> flagOut == ($past(flagOut) | $past(opExcept[4:0]));
    endproperty
    a_flagOp: assert property (p_flagOp) else $error("flag merge wrong");
    property p_flagKeep;
        !ctrlWr |=> (flagOut | $past(flagOut)) == flagOut;
    endproperty
    a_flagKeep: assert property (p_flagKeep) else $error("flag cleared alone");
    property p_errTrap;
        opValid && opExcept[5] |=> excTrap;
    endproperty
    a_errTrap: assert property (p_errTrap) else $error("error did not trap");
    property p_enTrap;
        opValid && (opExcept[4:0] & exceptEnable) != 5'h00 |=> excTrap;
    endproperty
    a_enTrap: assert property (p_enTrap) else $error("enabled exc no trap");
    property p_trapCause;
        excTrap |-> $past(opValid);
    endproperty
    a_trapCause: assert property (p_trapCause) else $error("trap without op");
    property p_ctrlWr;
        ctrlWr && !opValid |=> {causeOut, exceptEnable, flagOut} == $past(wrData[17:2]);
    endproperty
    a_ctrlWr: assert property (p_ctrlWr) else $error("field write lost");
    property p_rmWr;
        ctrlWr |=> roundingSelect == $past(wrData[1:0]) ##0
            {roundReserved, roundNearest} == {roundingSelect[1], roundingSelect == 2'h0};
    endproperty
    a_rmWr: assert property (p_rmWr) else $error("rounding mode wrong");
    property p_xfer;
        xferWrite |=> xferOut == $past(xferIn);
    endproperty
    a_xfer: assert property (p_xfer) else $error("transfer load lost");
endmodule

bind fsc_status_control fsc_status_control_chk #(.ADDR_W(ADDR_W)) u_chk (.clk(clk), .rst(rst),
    .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
    .opValid(opValid), .opExcept(opExcept), .xferWrite(xferWrite), .xferIn(xferIn),
    .xferOut(xferOut), .roundingSelect(roundingSelect), .roundNearest(roundNearest),
    .roundReserved(roundReserved), .exceptEnable(exceptEnable), .causeOut(causeOut),
    .flagOut(flagOut), .excTrap(excTrap));

// ---- tb_fpu_status_exception_control.sv ----
// Self-checking bench for the FP status/control block.
// Assumes fsc_cpu_model drives the op and transfer ports.
`timescale 1ns/1ps
module tb_fpu_status_exception_control;
    import fsc_pkg::*;
    logic clk, rst, wrStrobe, rdStrobe, opValid, xferWrite, excTrap, irq;
    logic roundNearest, roundReserved, bankSwap, pairMove, doublePrec, denormZero;
    logic [3:0] addr;
    logic [1:0] roundingSelect;
    fsc_word_t wrData, rdData, xferIn, xferOut;
    fsc_cause_t opExcept, causeOut;
    fsc_five_t exceptEnable, flagOut;
    int failures = 0, n_tests = 0;
    int cause, en, flag, rnd, hi, xfer, ist, imsk, trap;

    fsc_status_control #(.ADDR_W(4)) dut (.clk(clk), .rst(rst), .addr(addr), .wrData(wrData),
        .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .opValid(opValid),
        .opExcept(opExcept), .xferWrite(xferWrite), .xferIn(xferIn), .xferOut(xferOut),
        .roundingSelect(roundingSelect), .roundNearest(roundNearest),
        .roundReserved(roundReserved), .exceptEnable(exceptEnable), .causeOut(causeOut),
        .flagOut(flagOut), .bankSwap(bankSwap), .pairMove(pairMove), .doublePrec(doublePrec),
        .denormZero(denormZero), .excTrap(excTrap), .irq(irq));
    fsc_cpu_model cpu (.clk(clk), .opValid(opValid), .opExcept(opExcept),
        .xferWrite(xferWrite), .xferIn(xferIn));

    initial clk = 1'b0;
    always #4 clk = ~clk;

    // ---------------------------------------------------------------
    // Reference model and checks
    // ---------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rinit();
        cause = 0;
        en = 0;
        flag = 0;
        rnd = 1;
        hi = 1;
        xfer = 0;
        ist = 0;
        imsk = 0;
    endtask
    task automatic opm(input int e);
        trap = (e[5] || (e[4:0] & en) != 0) ? 1 : 0;
        cause = e;
        flag |= e[4:0];
        ist |= ((e != 0) ? 1 : 0) | (trap << 1);
    endtask
    task automatic chk();
        cmp(causeOut, cause);
        cmp(flagOut, flag);
        cmp(exceptEnable, en);
        cmp({roundReserved, roundNearest, roundingSelect}, {rnd > 1, rnd == 0, 2'(rnd)});
        cmp({bankSwap, pairMove, doublePrec, denormZero}, hi);
        cmp(irq, (ist & imsk) != 0);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        @(posedge clk);
        wrStrobe <= 1'b0;
        if (a == 4'h0) begin
            hi = d[21:18];
            cause = d[17:12];
            en = d[11:7];
            flag = d[6:2];
            rnd = d[1:0];
        end
        if (a == 4'h4) xfer = d;
        if (a == 4'hC) imsk = d[2:0];
        @(negedge clk);
    endtask
    task automatic rd(input logic [3:0] a);
        logic [31:0] e;
        case (a)
            4'h0: e = {10'h000, 4'(hi), 6'(cause), 5'(en), 5'(flag), 2'(rnd)};
            4'h4: e = xfer;
            4'h8: e = ist;
            4'hC: e = imsk;
            default: e = 32'h0;
        endcase
        @(posedge clk);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge clk);
        rdStrobe <= 1'b0;
        if (a == 4'h8) ist = 0;
        @(negedge clk);
        cmp(rdData, e);
        @(negedge clk);
        cmp(rdData, 32'h0);
    endtask
    task automatic ops(input int q[$], input int gap);
        cpu.run(q, gap);
        foreach (q[i]) opm(q[i]);
        @(negedge clk);
        cmp(causeOut, cause);
        cmp(excTrap, trap);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk();
    endtask

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        logic [3:0] a;
        void'($urandom(51202));
        {rst, addr, wrData, wrStrobe, rdStrobe} = {1'b1, 4'h0, 32'h0, 1'b0, 1'b0};
        xfer = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rinit();
        @(negedge clk);
        chk();
        rd(4'h0);
        for (int i = 0; i < 4; i++) begin
            wr(4'h0, 32'hFFC0_0000 | i);
            chk();
            rd(4'h0);
        end
        wr(4'h0, 32'h0000_0F81);
        for (int i = 0; i < 6; i++) begin
            ops('{1 << i}, 0);
            rd(4'h0);
        end
        wr(4'h0, 32'h0000_0001);
        chk();
        wr(4'hC, 32'h1);
        rd(4'h8);
        ops('{6'h10}, 1);
        rd(4'h8);
        chk();
        wr(4'hC, 32'h0);
        ops('{6'h20}, 2);
        rd(4'h8);
        ops('{6'h01, 6'h04, 6'h00}, 0);
        wr(4'h2, 32'hFFFF_FFFF);
        rd(4'h2);
        fork
            wr(4'h0, 32'h0000_0005);
            cpu.run('{6'h02}, 0);
        join
        opm(6'h02);
        @(negedge clk);
        chk();
        fork
            wr(4'h4, 32'hAAAA_5555);
            cpu.load(32'h1234_5678);
        join
        xfer = 32'h1234_5678;
        ist |= 4;
        cmp(xferOut, xfer);
        rd(4'h4);
        repeat (60) begin
            a = 4'($urandom);
            case ($urandom % 3)
                0: ops('{$urandom % 64, $urandom % 64}, $urandom % 3);
                1: wr((a == 4'h8) ? 4'h2 : a, $urandom);
                default: rd(a);
            endcase
        end
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rinit();
        @(negedge clk);
        chk();
        cmp(xferOut, xfer);
        rd(4'h0);
        report_and_stop();
    end

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        report_and_stop();
    end
endmodule
